// ---- main_osc_fail_detector.sv ----
// main oscillator failure detector with register port
// Operation
// [R1] the detect request leaves on the interrupt line shared with the watchdog.
// [R2] software reads the fail flag in the shared handler to tell the sources.
// [R3] the fail flag is set in the cycle a stop or restart request is raised.
// [R4] while the fail flag is set no further request is raised; writing 0 clears it.
// [R5] a stop in low-speed mode with detection on raises the request and starts the oscillator.
// [R6] after a low-speed stop the cpu stays on sub clock and peripherals move to the oscillator.
// [R7] software itself reselects the main clock after it restarts.
// [R8] software clears the peripheral-stop-in-wait bit before wait mode.
// [R9] software disables detection before stop mode or writing the halt bit.
// [R10] software keeps detection off when the main clock is 2MHz or lower.
// [R11] the absent bit reads 1 while the main clock is stopped and 0 once it runs; here it only changes while detection is enabled.
// [R12] detection runs only while the enable bit is 1.
// [R13] a stop is seen when the count of cycles without a main edge reaches a timeout.
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module main_osc_fail_detector (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       main_clk_in,
  input  wire logic       wdt_irq,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [7:0] rdata,
  output logic            shared_irq,
  output logic            oco_enable,
  output logic            periph_on_oco,
  output logic            cpu_on_sub
);
  typedef struct packed {
    logic [2:0] sync;
    logic       last;
    logic [7:0] idle_cnt;
    logic       osc_fail_detect_enable;
    logic       low_speed;
    logic       periph_clock_stop_in_wait;
    logic       main_clock_halt;
    logic       osc_fail_flag;
    logic       main_clock_absent;
    logic       oco_on;
    logic       periph_oco;
    logic       irq;
    logic [7:0] rdata;
  } state_t;

  state_t s;
  state_t next_s;
  logic   edge_seen;
  logic   stop_evt;
  logic   restart_evt;
  logic   evt;

  always_comb begin
    next_s = s;
    next_s.sync = {s.sync[1:0], main_clk_in};
    // level agreed by second and third stages
    if (s.sync[2] == s.sync[1]) begin
      next_s.last = s.sync[1];
    end
    edge_seen = (s.sync[2] == s.sync[1]) && (s.sync[1] != s.last);
    stop_evt = 1'b0;
    restart_evt = 1'b0;
    if (!s.osc_fail_detect_enable) begin // R12
      next_s.idle_cnt = osc_fail_pkg::CNT_ZERO;
    end else if (edge_seen) begin
      next_s.idle_cnt = osc_fail_pkg::CNT_ZERO;
      restart_evt = s.main_clock_absent;
    end else if (s.idle_cnt < osc_fail_pkg::STOP_CYCLES) begin // R13
      next_s.idle_cnt = s.idle_cnt + osc_fail_pkg::CNT_ONE;
    end else begin
      stop_evt = !s.main_clock_absent; // R13
    end
    if (stop_evt) begin
      next_s.main_clock_absent = 1'b1; // R11
    end else if (restart_evt) begin
      next_s.main_clock_absent = 1'b0; // R11
    end
    evt = (stop_evt || restart_evt) && !s.osc_fail_flag; // R4
    next_s.rdata = 8'h00;
    if (wr_en) begin
      case (addr)
        osc_fail_pkg::ADDR_CTRL: begin
          next_s.osc_fail_detect_enable =
            wdata[osc_fail_pkg::CTRL_EN_BIT];
          next_s.low_speed = wdata[osc_fail_pkg::CTRL_LOWSPD_BIT];
          next_s.periph_clock_stop_in_wait =
            wdata[osc_fail_pkg::CTRL_PSTOPW_BIT];
          next_s.main_clock_halt = wdata[osc_fail_pkg::CTRL_HALT_BIT];
        end
        osc_fail_pkg::ADDR_STATUS: begin
          if (!wdata[osc_fail_pkg::STAT_FLAG_BIT]) begin
            next_s.osc_fail_flag = 1'b0; // R4
          end
          next_s.oco_on = wdata[osc_fail_pkg::STAT_OCO_BIT];
        end
        osc_fail_pkg::ADDR_CLKSEL: begin
          next_s.periph_oco = wdata[osc_fail_pkg::CLKSEL_PERIPH_BIT]; // R7
        end
        default: begin
          next_s.rdata = 8'h00;
        end
      endcase
    end
    if (evt) begin
      next_s.osc_fail_flag = 1'b1; // R3
    end
    // hardware switch wins over a software write in the same cycle
    if (stop_evt && s.low_speed) begin
      next_s.oco_on = 1'b1; // R5
      next_s.periph_oco = 1'b1; // R6
    end
    if (rd_en) begin
      case (addr)
        osc_fail_pkg::ADDR_CTRL: begin
          next_s.rdata = {4'h0, s.main_clock_halt,
                          s.periph_clock_stop_in_wait, s.low_speed,
                          s.osc_fail_detect_enable};
        end
        osc_fail_pkg::ADDR_STATUS: begin
          next_s.rdata = {5'h00, s.oco_on, s.main_clock_absent,
                          s.osc_fail_flag};
        end
        osc_fail_pkg::ADDR_CLKSEL: begin
          next_s.rdata = {7'h00, s.periph_oco};
        end
        default: begin
          next_s.rdata = 8'h00;
        end
      endcase
    end
    // shared line: detector pulse or watchdog
    next_s.irq = evt || wdt_irq; // R1
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rdata         = s.rdata;
  assign shared_irq    = s.irq;
  assign oco_enable    = s.oco_on;
  assign periph_on_oco = s.periph_oco;
  assign cpu_on_sub    = s.low_speed; // R6

  a_flag_on_event: assert property (@(posedge ref_clk) disable iff (sys_rst)
    evt |=> s.osc_fail_flag && s.irq) // R3
    else $error("flag not set with request");

  a_no_repeat_req: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (s.osc_fail_flag && !wdt_irq) |=> !shared_irq) // R4
    else $error("request raised while flag set");

  a_lowspd_oco: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (stop_evt && s.low_speed) |=> (oco_enable && periph_on_oco)) // R5
    else $error("oscillator not started on stop");

  a_absent_tracks: assert property (@(posedge ref_clk) disable iff (sys_rst)
    stop_evt |=> s.main_clock_absent) // R11
    else $error("absent bit not set");

  a_disabled_quiet: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !s.osc_fail_detect_enable |-> !stop_evt && !restart_evt) // R12
    else $error("detection while disabled");

  a_timeout_count: assert property (@(posedge ref_clk) disable iff (sys_rst)
    stop_evt |-> s.idle_cnt == osc_fail_pkg::STOP_CYCLES) // R13
    else $error("stop before timeout");

  a_irq_shared: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wdt_irq |=> shared_irq) // R1
    else $error("watchdog not on shared line");

  a_cpu_stays_sub: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (stop_evt && s.low_speed) |=> cpu_on_sub) // R6
    else $error("cpu left sub clock");

  a_flag_holds: assert property (@(posedge ref_clk) disable iff (sys_rst) // R4
    s.osc_fail_flag && !(wr_en && addr == osc_fail_pkg::ADDR_STATUS)
    |=> s.osc_fail_flag)
    else $error("flag dropped without a write");

  a_flag_clears: assert property (@(posedge ref_clk) disable iff (sys_rst) // R4
    wr_en && addr == osc_fail_pkg::ADDR_STATUS
    && !wdata[osc_fail_pkg::STAT_FLAG_BIT] && !evt |=> !s.osc_fail_flag)
    else $error("flag not cleared by write");

  a_flag_rise: assert property (@(posedge ref_clk) disable iff (sys_rst) // R3
    $rose(s.osc_fail_flag)
    |-> $past(evt))
    else $error("flag set without request");

  a_irq_cause: assert property (@(posedge ref_clk) disable iff (sys_rst) // R1
    shared_irq
    |-> $past(evt || wdt_irq))
    else $error("request without a source");

  a_absent_clears: assert property (@(posedge ref_clk) disable iff (sys_rst) // R11
    restart_evt
    |=> !s.main_clock_absent)
    else $error("absent bit not cleared");

  a_absent_steady: assert property (@(posedge ref_clk) disable iff (sys_rst) // R11
    !stop_evt && !restart_evt
    |=> $stable(s.main_clock_absent))
    else $error("absent bit moved without event");

  a_restart_absent: assert property (@(posedge ref_clk) disable iff (sys_rst) // R11
    restart_evt
    |-> s.main_clock_absent)
    else $error("restart while clock present");

  a_stop_once: assert property (@(posedge ref_clk) disable iff (sys_rst) // R13
    stop_evt
    |-> !s.main_clock_absent)
    else $error("stop seen twice");

  a_count_bound: assert property (@(posedge ref_clk) disable iff (sys_rst) // R13
    1'b1
    |-> s.idle_cnt <= osc_fail_pkg::STOP_CYCLES)
    else $error("idle count past timeout");

  a_count_off: assert property (@(posedge ref_clk) disable iff (sys_rst) // R12
    !s.osc_fail_detect_enable
    |=> s.idle_cnt == osc_fail_pkg::CNT_ZERO)
    else $error("idle count runs while off");

  a_count_edge: assert property (@(posedge ref_clk) disable iff (sys_rst) // R13
    s.osc_fail_detect_enable && edge_seen
    |=> s.idle_cnt == osc_fail_pkg::CNT_ZERO)
    else $error("idle count not cleared by edge");

  a_count_step: assert property (@(posedge ref_clk) disable iff (sys_rst) // R13
    s.osc_fail_detect_enable && !edge_seen
    && s.idle_cnt < osc_fail_pkg::STOP_CYCLES
    |=> s.idle_cnt == $past(s.idle_cnt) + osc_fail_pkg::CNT_ONE)
    else $error("idle count did not step");

  a_rdata_idle: assert property (@(posedge ref_clk) disable iff (sys_rst) // R2
    !rd_en
    |=> rdata == 8'h00)
    else $error("read data without read");

  a_flag_read: assert property (@(posedge ref_clk) disable iff (sys_rst) // R2
    rd_en && addr == osc_fail_pkg::ADDR_STATUS
    |=> rdata[osc_fail_pkg::STAT_FLAG_BIT] == $past(s.osc_fail_flag))
    else $error("flag read wrong");

  a_absent_read: assert property (@(posedge ref_clk) disable iff (sys_rst) // R11
    rd_en && addr == osc_fail_pkg::ADDR_STATUS
    |=> rdata[osc_fail_pkg::STAT_ABSENT_BIT] == $past(s.main_clock_absent))
    else $error("absent read wrong");

  a_ctrl_read: assert property (@(posedge ref_clk) disable iff (sys_rst) // R12
    rd_en && addr == osc_fail_pkg::ADDR_CTRL
    |=> rdata[osc_fail_pkg::CTRL_EN_BIT] == $past(s.osc_fail_detect_enable))
    else $error("enable read wrong");

  a_oco_holds: assert property (@(posedge ref_clk) disable iff (sys_rst) // R5
    s.oco_on && !(wr_en && addr == osc_fail_pkg::ADDR_STATUS)
    |=> s.oco_on)
    else $error("oscillator stopped by itself");

  a_periph_holds: assert property (@(posedge ref_clk) disable iff (sys_rst) // R6
    s.periph_oco && !(wr_en && addr == osc_fail_pkg::ADDR_CLKSEL)
    |=> s.periph_oco)
    else $error("peripheral clock left oscillator");

  a_periph_write: assert property (@(posedge ref_clk) disable iff (sys_rst) // R7
    wr_en && addr == osc_fail_pkg::ADDR_CLKSEL
    && !(stop_evt && s.low_speed)
    |=> periph_on_oco == $past(wdata[osc_fail_pkg::CLKSEL_PERIPH_BIT]))
    else $error("clock select write lost");

  a_no_auto_back: assert property (@(posedge ref_clk) disable iff (sys_rst) // R7
    restart_evt && !(wr_en && addr == osc_fail_pkg::ADDR_CLKSEL)
    |=> $stable(periph_on_oco))
    else $error("clock select moved on restart");

  a_fast_no_oco: assert property (@(posedge ref_clk) disable iff (sys_rst) // R5
    stop_evt && !s.low_speed && !(wr_en && addr == osc_fail_pkg::ADDR_STATUS)
    |=> $stable(oco_enable))
    else $error("oscillator moved outside low speed");

  a_cpu_follows: assert property (@(posedge ref_clk) disable iff (sys_rst) // R6
    wr_en && addr == osc_fail_pkg::ADDR_CTRL
    |=> cpu_on_sub == $past(wdata[osc_fail_pkg::CTRL_LOWSPD_BIT]))
    else $error("cpu clock select not written");

  a_enable_write: assert property (@(posedge ref_clk) disable iff (sys_rst) // R12
    wr_en && addr == osc_fail_pkg::ADDR_CTRL
    |=> s.osc_fail_detect_enable == $past(wdata[osc_fail_pkg::CTRL_EN_BIT]))
    else $error("enable not written");

  a_halt_stored: assert property (@(posedge ref_clk) disable iff (sys_rst) // R9
    wr_en && addr == osc_fail_pkg::ADDR_CTRL
    |=> s.main_clock_halt == $past(wdata[osc_fail_pkg::CTRL_HALT_BIT]))
    else $error("halt bit not written");

  a_pstopw_stored: assert property (@(posedge ref_clk) disable iff (sys_rst) // R8
    wr_en && addr == osc_fail_pkg::ADDR_CTRL
    |=> s.periph_clock_stop_in_wait == $past(wdata[osc_fail_pkg::CTRL_PSTOPW_BIT]))
    else $error("wait stop bit not written");

  a_last_agreed: assert property (@(posedge ref_clk) disable iff (sys_rst) // R13
    s.sync[2] == s.sync[1]
    |=> s.last == $past(s.sync[1]))
    else $error("agreed level not taken");
endmodule
`default_nettype wire

// ---- osc_fail_pkg.sv ----
// constants for the main oscillator failure detector
package osc_fail_pkg;
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_CLKSEL = 4'h2;
  localparam int         CTRL_EN_BIT      = 0;
  localparam int         CTRL_LOWSPD_BIT  = 1;
  localparam int         CTRL_PSTOPW_BIT  = 2;
  localparam int         CTRL_HALT_BIT    = 3;
  localparam int         STAT_FLAG_BIT    = 0;
  localparam int         STAT_ABSENT_BIT  = 1;
  localparam int         STAT_OCO_BIT     = 2;
  localparam int         CLKSEL_PERIPH_BIT = 0;
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam int         STOP_TIMEOUT_NS = 1000;
  localparam int         CLK_PERIOD_NS   = 25;
  localparam int         STOP_CYCLES_I   = STOP_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam logic [7:0] STOP_CYCLES  = STOP_CYCLES_I[7:0];
  localparam logic [7:0] CNT_ZERO     = 8'h00;
  localparam logic [7:0] CNT_ONE      = 8'h01;
endpackage

// ---- main_osc_model.sv ----
// oscillator model driving the main clock input
`timescale 1ns/1ps
`default_nettype none
module main_osc_model (
  input  wire logic run,
  output logic      main_clk
);
  initial main_clk = 1'b0;
  // 16.7 MHz, well above the lowest usable rate; holds its level when stopped
  always #30 if (run) main_clk = ~main_clk;
endmodule
`default_nettype wire

// ---- main_osc_fail_detector_bench.sv ----
// bench for the main oscillator failure detector
`timescale 1ns/1ps
`default_nettype none
module main_osc_fail_detector_bench;
  logic       ref_clk, sys_rst, main_clk_in, wdt_irq, wr_en, rd_en, run;
  logic [3:0] addr;
  logic [7:0] wdata, rdata;
  logic       shared_irq, oco_enable, periph_on_oco, cpu_on_sub;
  int         err_count = 0, n_checks = 0, cyc = 0;
  main_osc_model osc_u (.run(run), .main_clk(main_clk_in));
  main_osc_fail_detector dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .main_clk_in(main_clk_in), .wdt_irq(wdt_irq), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .shared_irq(shared_irq), .oco_enable(oco_enable),
    .periph_on_oco(periph_on_oco), .cpu_on_sub(cpu_on_sub));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  // counts request pulses over n cycles
  task automatic irqs(input int n, input logic [7:0] exp);
    logic [7:0] k;
    k = 8'h00;
    repeat (n) begin
      @(posedge ref_clk);
      #1 k = k + {7'h00, shared_irq};
    end
    chk(k, exp);
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      report_and_stop();
    end
  end
  initial begin
    sys_rst = 1'b1;
    {wdt_irq, wr_en, rd_en, addr, wdata} = '0;
    run = 1'b1;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(osc_fail_pkg::ADDR_CTRL, 8'h00);
    rd(osc_fail_pkg::ADDR_STATUS, 8'h00);
    rd(4'h5, 8'h00);
    @(posedge ref_clk);
    wdt_irq <= 1'b1;
    @(posedge ref_clk);
    wdt_irq <= 1'b0;
    #1 chk({7'h00, shared_irq}, 8'h01);
    rd(osc_fail_pkg::ADDR_STATUS, 8'h00);
    $display("test reset and watchdog done");
    wr(osc_fail_pkg::ADDR_CTRL, 8'h02);
    run <= 1'b0;
    irqs(60, 8'h00);
    rd(osc_fail_pkg::ADDR_STATUS, 8'h00);
    run <= 1'b1;
    wr(osc_fail_pkg::ADDR_CTRL, 8'h03);
    run <= 1'b0;
    irqs(60, 8'h01);
    chk({5'h00, oco_enable, periph_on_oco, cpu_on_sub}, 8'h07);
    rd(osc_fail_pkg::ADDR_CTRL, 8'h03);
    rd(osc_fail_pkg::ADDR_STATUS, 8'h07);
    $display("test stop detect done");
    wr(osc_fail_pkg::ADDR_STATUS, 8'h04);
    run <= 1'b1;
    irqs(20, 8'h01);
    rd(osc_fail_pkg::ADDR_STATUS, 8'h05);
    run <= 1'b0;
    irqs(60, 8'h00);
    rd(osc_fail_pkg::ADDR_STATUS, 8'h07);
    $display("test restart and suppress done");
    wr(osc_fail_pkg::ADDR_CTRL, 8'h00);
    run <= 1'b1;
    wr(osc_fail_pkg::ADDR_CLKSEL, 8'h00);
    #1 chk({7'h00, periph_on_oco}, 8'h00);
    rd(osc_fail_pkg::ADDR_CLKSEL, 8'h00);
    $display("test reselect done");
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(osc_fail_pkg::ADDR_STATUS, 8'h00);
    $display("test mid-run reset done");
    report_and_stop();
  end
endmodule
`default_nettype wire
